// File: rtl/dmacc_map.svh
// Register offsets, field positions and reset values of the DMA channel configuration block.
// Overview of operation
// - Six word registers at channel offsets 0x0..0x14.
// - Control bit 0 enables channel transfers.
// - Control bit 1 enables complete interrupt.
// - Control bit 2 enables halfway interrupt.
// - Control bit 3 enables error interrupt.
// - Control bit 4 selects transfer direction.
// - Control bit 5 selects circular auto reload.
// - Control bit 6 steps peripheral address.
// - Control bit 7 steps memory address.
// - Bits 9:8 peripheral width; halfword aligns.
// - Peripheral word width ignores address bits 1:0.
// - Bits 13:12 give the channel priority.
// - Control bit 14 enables memory copy mode.
// - Item count is 16 bits, 0 to 65535.
// - Item count writable only while disabled.
// - Count decrements after each error-free transfer.
// - Completion holds zero, or reloads if circular.
// - Zero count serves no transaction at all.
// - Peripheral address register holds 32-bit base.
// - Memory width forces memory address alignment.
// - Any-flag clear wipes all three channel flags.
`ifndef DMACC_MAP_SVH
`define DMACC_MAP_SVH
`define DMACC_OFS_CONTROL   12'h000
`define DMACC_OFS_COUNT     12'h004
`define DMACC_OFS_PERIPH    12'h008
`define DMACC_OFS_MEMORY    12'h00c
`define DMACC_OFS_FLAGS     12'h010
`define DMACC_OFS_FLAGCLR   12'h014
`define DMACC_CTRL_MASK     32'h00007fff
`define DMACC_COUNT_MASK    32'h0000ffff
`define DMACC_RESET_VALUE   32'h00000000
`define DMACC_FLAG_COMPLETE 0
`define DMACC_FLAG_HALFWAY  1
`define DMACC_FLAG_ERROR    2
`define DMACC_FLAG_ANY      3
`endif

// File: rtl/dmacc_pkg.sv
// Types of the DMA channel configuration block.
package dmacc_pkg;
   typedef struct packed {
      logic       memory_copy_mode;
      logic [1:0] channel_rank;
      logic [1:0] memory_element_width;
      logic [1:0] periph_element_width;
      logic       memory_addr_step;
      logic       periph_addr_step;
      logic       auto_reload_loop;
      logic       dir_from_memory;
      logic       error_irq_enable;
      logic       halfway_irq_enable;
      logic       complete_irq_enable;
      logic       channel_enable;
   } dmacc_ctrl_s;

   typedef enum logic [1:0] {
      DMACC_IDLE = 2'b00,
      DMACC_BUSY = 2'b01,
      DMACC_DONE = 2'b11
   } dmacc_state_e;

   typedef struct packed {
      dmacc_ctrl_s  ctrl;
      logic [15:0]  items_remaining;
      logic [15:0]  items_programmed;
      logic [31:0]  periph_base_pointer;
      logic [31:0]  mem_base_pointer;
      logic [31:0]  periph_cur;
      logic [31:0]  mem_cur;
      logic         complete_flag;
      logic         halfway_flag;
      logic         error_flag;
      logic [31:0]  prdata;
      dmacc_state_e state;
   } dmacc_state_s;
endpackage

// File: rtl/dmacc_channel.sv
// One DMA channel: APB registers, item counting, address stepping and flags.
`timescale 1ns/100ps
`include "dmacc_map.svh"
module dmacc_channel
   import dmacc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             XFER_REQ,
   output logic             XFER_DIR_FROM_MEM,
   output logic             XFER_MEM_COPY,
   output logic      [1:0]  XFER_RANK,
   output logic      [31:0] XFER_SRC_ADDR,
   output logic      [31:0] XFER_DST_ADDR,
   output logic      [1:0]  XFER_PERIPH_ELEMENT_WIDTH,
   output logic      [1:0]  XFER_MEMORY_ELEMENT_WIDTH,
   input  wire logic        XFER_DONE,
   input  wire logic        XFER_ERROR,
   output logic             IRQ
);

   dmacc_state_s s_r;
   dmacc_state_s s_nxt;

   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic [31:0] periph_eff;
   logic [31:0] mem_eff;
   logic        req;
   logic [14:0] pwdata_ctrl;
   logic [15:0] pwdata_count;

   function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [1:0] w);
      logic [31:0] r;
      r = a;
      if (w == 2'b01) begin
         r[0] = 1'b0;
      end else if (w == 2'b10) begin
         r[1:0] = 2'b00;
      end
      return r;
   endfunction

   function automatic logic [31:0] step_of(input logic [1:0] w);
      logic [31:0] r;
      case (w)
         2'b00:   r = 32'h00000001;
         2'b01:   r = 32'h00000002;
         default: r = 32'h00000004;
      endcase
      return r;
   endfunction

   assign wr_en   = PSEL & PENABLE & PWRITE;
   assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
   assign mapped  = (PADDR == `DMACC_OFS_CONTROL) || (PADDR == `DMACC_OFS_COUNT) ||
                    (PADDR == `DMACC_OFS_PERIPH) || (PADDR == `DMACC_OFS_MEMORY) ||
                    (PADDR == `DMACC_OFS_FLAGS) || (PADDR == `DMACC_OFS_FLAGCLR);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA  = s_r.prdata;

   assign pwdata_ctrl  = PWDATA[14:0];
   assign pwdata_count = PWDATA[15:0];

   assign periph_eff = align_addr(s_r.periph_cur, s_r.ctrl.periph_element_width);
   assign mem_eff    = align_addr(s_r.mem_cur, s_r.ctrl.memory_element_width);

   // Requests only while enabled with a nonzero count.
   assign req = s_r.ctrl.channel_enable && (s_r.items_remaining != 16'h0000) && (s_r.state == DMACC_BUSY);

   assign XFER_REQ          = req;
   assign XFER_DIR_FROM_MEM = s_r.ctrl.dir_from_memory;
   assign XFER_MEM_COPY     = s_r.ctrl.memory_copy_mode;
   assign XFER_RANK         = s_r.ctrl.channel_rank;
   assign XFER_SRC_ADDR     = s_r.ctrl.dir_from_memory ? mem_eff : periph_eff;
   assign XFER_DST_ADDR     = s_r.ctrl.dir_from_memory ? periph_eff : mem_eff;
   assign XFER_PERIPH_ELEMENT_WIDTH        = s_r.ctrl.periph_element_width;
   assign XFER_MEMORY_ELEMENT_WIDTH        = s_r.ctrl.memory_element_width;

   // Interrupt request from any enabled flag.
   assign IRQ = (s_r.complete_flag & s_r.ctrl.complete_irq_enable) |
                (s_r.halfway_flag & s_r.ctrl.halfway_irq_enable) |
                (s_r.error_flag & s_r.ctrl.error_irq_enable);

   always_comb begin
      logic        done_ok;
      logic [15:0] left;
      logic        clr_all;
      s_nxt   = s_r;
      done_ok = req & XFER_DONE & ~XFER_ERROR;
      left    = s_r.items_remaining - 16'h0001;
      clr_all = wr_en && (PADDR == `DMACC_OFS_FLAGCLR) && PWDATA[`DMACC_FLAG_ANY];

      // Read data is captured in the setup phase.
      if (rd_en) begin
         case (PADDR)
            `DMACC_OFS_CONTROL: s_nxt.prdata = {17'h0, s_r.ctrl};
            `DMACC_OFS_COUNT:   s_nxt.prdata = {16'h0000, s_r.items_remaining};
            `DMACC_OFS_PERIPH:  s_nxt.prdata = s_r.periph_base_pointer;
            `DMACC_OFS_MEMORY:  s_nxt.prdata = s_r.mem_base_pointer;
            `DMACC_OFS_FLAGS:   s_nxt.prdata = {28'h0000000, IRQ, s_r.error_flag,
                                               s_r.halfway_flag, s_r.complete_flag};
            default:            s_nxt.prdata = 32'h00000000;
         endcase
      end

      // Flag clears first, so hardware sets below win.
      if (clr_all) begin
         s_nxt.complete_flag = 1'b0;
         s_nxt.halfway_flag  = 1'b0;
         s_nxt.error_flag    = 1'b0;
      end else if (wr_en && (PADDR == `DMACC_OFS_FLAGCLR)) begin
         if (PWDATA[`DMACC_FLAG_COMPLETE]) s_nxt.complete_flag = 1'b0;
         if (PWDATA[`DMACC_FLAG_HALFWAY])  s_nxt.halfway_flag  = 1'b0;
         if (PWDATA[`DMACC_FLAG_ERROR])    s_nxt.error_flag    = 1'b0;
      end

      if (wr_en) begin
         case (PADDR)
            `DMACC_OFS_CONTROL: s_nxt.ctrl = dmacc_ctrl_s'(PWDATA[14:0]);
            `DMACC_OFS_COUNT: begin
               if (!s_r.ctrl.channel_enable) begin
                  s_nxt.items_remaining  = PWDATA[15:0];
                  s_nxt.items_programmed = PWDATA[15:0];
               end
            end
            `DMACC_OFS_PERIPH: begin
               s_nxt.periph_base_pointer = PWDATA;
               s_nxt.periph_cur          = PWDATA;
            end
            `DMACC_OFS_MEMORY: begin
               s_nxt.mem_base_pointer = PWDATA;
               s_nxt.mem_cur          = PWDATA;
            end
            default: ;
         endcase
      end

      case (s_r.state)
         DMACC_IDLE: begin
            if (s_r.ctrl.channel_enable) begin
               s_nxt.state      = DMACC_BUSY;
               s_nxt.periph_cur = s_r.periph_base_pointer;
               s_nxt.mem_cur    = s_r.mem_base_pointer;
            end
         end
         DMACC_BUSY: begin
            if (!s_r.ctrl.channel_enable) begin
               s_nxt.state = DMACC_IDLE;
            end else if (req && XFER_DONE && XFER_ERROR) begin
               s_nxt.error_flag = 1'b1;
               s_nxt.state      = DMACC_DONE;
            end else if (done_ok) begin
               s_nxt.items_remaining = left;
               if (s_r.ctrl.periph_addr_step) s_nxt.periph_cur = s_r.periph_cur + step_of(s_r.ctrl.periph_element_width);
               if (s_r.ctrl.memory_addr_step) s_nxt.mem_cur = s_r.mem_cur + step_of(s_r.ctrl.memory_element_width);
               if (left == (s_r.items_programmed >> 1)) s_nxt.halfway_flag = 1'b1;
               if (left == 16'h0000) begin
                  s_nxt.complete_flag = 1'b1;
                  if (s_r.ctrl.auto_reload_loop) begin
                     s_nxt.items_remaining = s_r.items_programmed;
                     s_nxt.periph_cur      = s_r.periph_base_pointer;
                     s_nxt.mem_cur         = s_r.mem_base_pointer;
                  end else begin
                     s_nxt.state = DMACC_DONE;
                  end
               end
            end
         end
         DMACC_DONE: begin
            if (!s_r.ctrl.channel_enable) s_nxt.state = DMACC_IDLE;
         end
         default: s_nxt.state = DMACC_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   a_count_locked: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.channel_enable && !(req && XFER_DONE)) |=> $stable(s_r.items_remaining))
      else $error("count changed while enabled without a transfer");
   a_count_decr: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && s_r.items_remaining > 16'h0001)
      |=> s_r.items_remaining == $past(s_r.items_remaining) - 16'h0001)
      else $error("count did not decrement");
   a_zero_idle: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.items_remaining == 16'h0000) |-> !XFER_REQ)
      else $error("request with zero count");
   a_disabled_idle: assert property (@(posedge CLK) disable iff (!RST_B)
      !s_r.ctrl.channel_enable |-> !XFER_REQ)
      else $error("request while disabled");
   a_reload_auto_reload_loop: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && s_r.items_remaining == 16'h0001 && s_r.ctrl.auto_reload_loop)
      |=> s_r.items_remaining == s_r.items_programmed && s_r.complete_flag)
      else $error("circular reload missing");
   a_stop_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && s_r.items_remaining == 16'h0001 && !s_r.ctrl.auto_reload_loop)
      |=> s_r.items_remaining == 16'h0000 ##1 s_r.items_remaining == 16'h0000)
      else $error("normal mode did not hold zero");
   a_irq_gate: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.complete_flag && s_r.ctrl.complete_irq_enable) |-> IRQ)
      else $error("interrupt not raised");
   a_clear_all: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_FLAGCLR && PWDATA[`DMACC_FLAG_ANY] && !req)
      |=> !s_r.complete_flag && !s_r.halfway_flag && !s_r.error_flag)
      else $error("flags not cleared");
   a_word_align: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.periph_element_width == 2'b10 && XFER_REQ && !s_r.ctrl.dir_from_memory)
      |-> XFER_SRC_ADDR[1:0] == 2'b00)
      else $error("peripheral address not word aligned");

   a_ctrl_write: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_CONTROL)
      |=> s_r.ctrl == $past(pwdata_ctrl))
      else $error("control write not stored");
   a_periph_write: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_PERIPH)
      |=> s_r.periph_base_pointer == $past(PWDATA))
      else $error("peripheral address write not stored");
   a_mem_write: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_MEMORY)
      |=> s_r.mem_base_pointer == $past(PWDATA))
      else $error("memory address write not stored");
   a_count_write: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_COUNT && !s_r.ctrl.channel_enable)
      |=> s_r.items_remaining == $past(pwdata_count))
      else $error("count write while disabled not stored");
   a_count_refused: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_COUNT && s_r.ctrl.channel_enable)
      |=> $stable(s_r.items_programmed))
      else $error("count write accepted while enabled");
   a_count_read: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_en && PADDR == `DMACC_OFS_COUNT)
      |=> PRDATA == {16'h0000, $past(s_r.items_remaining)})
      else $error("count read does not show remaining items");
   a_ctrl_read: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_en && PADDR == `DMACC_OFS_CONTROL)
      |=> PRDATA == {17'h0, $past(s_r.ctrl)})
      else $error("control read mismatch");
   a_periph_read: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_en && PADDR == `DMACC_OFS_PERIPH)
      |=> PRDATA == $past(s_r.periph_base_pointer))
      else $error("peripheral address read mismatch");
   a_mem_read: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_en && PADDR == `DMACC_OFS_MEMORY)
      |=> PRDATA == $past(s_r.mem_base_pointer))
      else $error("memory address read mismatch");
   a_flags_read: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_en && PADDR == `DMACC_OFS_FLAGS)
      |=> PRDATA[3] == $past(IRQ))
      else $error("flag read does not show interrupt request");
   a_unmapped_err: assert property (@(posedge CLK) disable iff (!RST_B)
      (PSEL && PENABLE && PADDR == 12'h018)
      |-> PSLVERR)
      else $error("unmapped access without error response");

   a_irq_halfway: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.halfway_flag && s_r.ctrl.halfway_irq_enable)
      |-> IRQ)
      else $error("halfway interrupt not raised");
   a_irq_error: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.error_flag && s_r.ctrl.error_irq_enable)
      |-> IRQ)
      else $error("error interrupt not raised");
   a_irq_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
      (!(s_r.complete_flag && s_r.ctrl.complete_irq_enable) &&
       !(s_r.halfway_flag && s_r.ctrl.halfway_irq_enable) &&
       !(s_r.error_flag && s_r.ctrl.error_irq_enable))
      |-> !IRQ)
      else $error("interrupt without an enabled flag");

   a_dir_periph: assert property (@(posedge CLK) disable iff (!RST_B)
      (!s_r.ctrl.dir_from_memory && s_r.ctrl.periph_element_width == 2'b00)
      |-> XFER_SRC_ADDR == s_r.periph_cur)
      else $error("source is not the peripheral side");
   a_dir_memory: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.dir_from_memory && s_r.ctrl.memory_element_width == 2'b00)
      |-> XFER_SRC_ADDR == s_r.mem_cur)
      else $error("source is not the memory side");
   a_periph_half: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.periph_element_width == 2'b01)
      |-> (s_r.ctrl.dir_from_memory ? XFER_DST_ADDR[0] : XFER_SRC_ADDR[0]) == 1'b0)
      else $error("peripheral address not halfword aligned");
   a_mem_half: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.memory_element_width == 2'b01)
      |-> (s_r.ctrl.dir_from_memory ? XFER_SRC_ADDR[0] : XFER_DST_ADDR[0]) == 1'b0)
      else $error("memory address not halfword aligned");
   a_mem_word: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.ctrl.memory_element_width == 2'b10)
      |-> (s_r.ctrl.dir_from_memory ? XFER_SRC_ADDR[1:0] : XFER_DST_ADDR[1:0]) == 2'b00)
      else $error("memory address not word aligned");

   a_periph_step: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && !wr_en && s_r.items_remaining > 16'h0001 &&
       s_r.ctrl.periph_addr_step && s_r.ctrl.periph_element_width == 2'b10)
      |=> s_r.periph_cur == $past(s_r.periph_cur) + 32'h00000004)
      else $error("peripheral address did not step by a word");
   a_periph_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && !wr_en && s_r.items_remaining > 16'h0001 &&
       !s_r.ctrl.periph_addr_step)
      |=> $stable(s_r.periph_cur))
      else $error("peripheral address moved without stepping");
   a_mem_step: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && !wr_en && s_r.items_remaining > 16'h0001 &&
       s_r.ctrl.memory_addr_step && s_r.ctrl.memory_element_width == 2'b01)
      |=> s_r.mem_cur == $past(s_r.mem_cur) + 32'h00000002)
      else $error("memory address did not step by a halfword");
   a_mem_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && !wr_en && s_r.items_remaining > 16'h0001 &&
       !s_r.ctrl.memory_addr_step)
      |=> $stable(s_r.mem_cur))
      else $error("memory address moved without stepping");

   a_half_set: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR &&
       s_r.items_remaining == (s_r.items_programmed >> 1) + 16'h0001)
      |=> s_r.halfway_flag)
      else $error("halfway flag not set");
   a_done_set: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && s_r.items_remaining == 16'h0001)
      |=> s_r.complete_flag)
      else $error("complete flag not set");
   a_error_set: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && XFER_ERROR)
      |=> s_r.error_flag && !XFER_REQ)
      else $error("error did not stop the channel");
   a_error_count: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && XFER_ERROR)
      |=> $stable(s_r.items_remaining))
      else $error("failed transfer changed the count");
   a_clear_one: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_en && PADDR == `DMACC_OFS_FLAGCLR && PWDATA[`DMACC_FLAG_COMPLETE] && !req)
      |=> !s_r.complete_flag)
      else $error("complete flag not cleared");

   a_auto_reload_loop_busy: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && s_r.items_remaining == 16'h0001 && s_r.ctrl.auto_reload_loop)
      |=> s_r.state == DMACC_BUSY)
      else $error("circular channel stopped after wrap");
   a_auto_reload_loop_rewind: assert property (@(posedge CLK) disable iff (!RST_B)
      (req && XFER_DONE && !XFER_ERROR && !wr_en && s_r.items_remaining == 16'h0001 &&
       s_r.ctrl.auto_reload_loop)
      |=> s_r.periph_cur == s_r.periph_base_pointer && s_r.mem_cur == s_r.mem_base_pointer)
      else $error("addresses not rewound on wrap");
   a_done_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.state == DMACC_DONE && s_r.ctrl.channel_enable)
      |=> s_r.state == DMACC_DONE)
      else $error("finished channel restarted while enabled");
   a_enable_load: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.state == DMACC_IDLE && s_r.ctrl.channel_enable && !wr_en)
      |=> s_r.state == DMACC_BUSY && s_r.periph_cur == s_r.periph_base_pointer)
      else $error("enable did not start the channel");
   a_idle_disable: assert property (@(posedge CLK) disable iff (!RST_B)
      !s_r.ctrl.channel_enable
      |=> s_r.state != DMACC_BUSY)
      else $error("disabled channel still busy");

   c_complete: cover property (@(posedge CLK) disable iff (!RST_B) $rose(s_r.complete_flag));
   c_halfway:  cover property (@(posedge CLK) disable iff (!RST_B) $rose(s_r.halfway_flag));
   c_reload:   cover property (@(posedge CLK) disable iff (!RST_B)
      s_r.ctrl.auto_reload_loop && $rose(s_r.complete_flag));
   c_error:    cover property (@(posedge CLK) disable iff (!RST_B) $rose(s_r.error_flag));
   c_refused:  cover property (@(posedge CLK) disable iff (!RST_B)
      wr_en && PADDR == `DMACC_OFS_COUNT && s_r.ctrl.channel_enable);

endmodule // dmacc_channel

// File: tb/dmacc_engine_model.sv
// Transfer engine model that answers channel requests with completion pulses.
`timescale 1ns/100ps
module dmacc_engine_model #(
   parameter int LAT = 2
) (
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       XFER_REQ,
   input  wire logic [7:0] grant,
   input  wire logic       err_cmd,
   output logic            XFER_DONE,
   output logic            XFER_ERROR,
   output logic      [7:0] served
);
   int dly;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         dly        <= 0;
         XFER_DONE  <= 1'b0;
         XFER_ERROR <= 1'b0;
         served     <= 8'h00;
      end else begin
         XFER_DONE  <= 1'b0;
         XFER_ERROR <= 1'b0;
         // Completes items until served reaches grant, only while a request stands.
         if (XFER_REQ && !XFER_DONE && served < grant) begin
            if (dly == LAT) begin
               dly        <= 0;
               XFER_DONE  <= 1'b1;
               XFER_ERROR <= err_cmd;
               served     <= served + 8'h01;
            end else begin
               dly <= dly + 1;
            end
         end
      end
   end
endmodule // dmacc_engine_model

// File: tb/dmacc_channel_tb_top.sv
// Testbench of the DMA channel configuration block.
`timescale 1ns/100ps
module dmacc_channel_tb_top;
   import dmacc_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, src, dst, rd;
   logic        pready, pslverr, req, dirm, mcopy, done, xerr, irq, er, err_cmd = 1'b0;
   logic [1:0]  rank, psz, msz;
   logic [7:0]  grant = 8'h00, served;
   int          fails = 0, tests_run = 0, cyc = 0;
   always #2.5 clk = ~clk;
   dmacc_channel dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .XFER_REQ(req), .XFER_DIR_FROM_MEM(dirm), .XFER_MEM_COPY(mcopy), .XFER_RANK(rank),
      .XFER_SRC_ADDR(src), .XFER_DST_ADDR(dst), .XFER_PERIPH_ELEMENT_WIDTH(psz), .XFER_MEMORY_ELEMENT_WIDTH(msz),
      .XFER_DONE(done), .XFER_ERROR(xerr), .IRQ(irq));
   dmacc_engine_model eng_u (.CLK(clk), .RST_B(rst_b), .XFER_REQ(req), .grant(grant),
      .err_cmd(err_cmd), .XFER_DONE(done), .XFER_ERROR(xerr), .served(served));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_req(input logic v);
      for (int i = 0; i < 200 && req !== v; i++) @(negedge clk);
   endtask
   task automatic wait_served(input logic [7:0] n);
      grant <= n;
      for (int i = 0; i < 300 && served !== n; i++) @(negedge clk);
      repeat (2) @(negedge clk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 12'h000, 32'h00007ffe);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h00007ffe);
      chk({24'h0, mcopy, rank, msz, psz, dirm}, {24'h0, 8'hff});
      chk({31'h0, req}, 32'h0);
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b1, 12'h008, 32'h00001003);
      apb(1'b1, 12'h00c, 32'h00002003);
      apb(1'b1, 12'h000, 32'h000006c3);
      wait_req(1'b1);
      chk({31'h0, req}, 32'h1);
      chk(src, 32'h00001000);
      chk(dst, 32'h00002002);
      apb(1'b1, 12'h004, 32'h9);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h4);
      wait_served(8'd1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h3);
      chk(src, 32'h00001004);
      chk(dst, 32'h00002004);
      wait_served(8'd4);
      wait_req(1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'hb);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h014, 32'h8);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h2);
      apb(1'b1, 12'h000, 32'h00000025);
      wait_served(8'd6);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h2);
      chk({31'h0, req}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h014, 32'h8);
      apb(1'b1, 12'h004, 32'h3);
      err_cmd <= 1'b1;
      apb(1'b1, 12'h000, 32'h00000009);
      wait_served(8'd7);
      wait_req(1'b0);
      chk({31'h0, req}, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, rd[2]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      err_cmd <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h000, 32'h00000111);
      wait_req(1'b1);
      chk(src, 32'h00002003);
      chk(dst, 32'h00001002);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h00000001);
      repeat (8) @(negedge clk);
      chk({31'h0, req}, 32'h0);
      end_sim();
   end
endmodule // dmacc_channel_tb_top
